// *** sim/dpc_spi_master.sv ***
// SPI master model that sends 16-bit frames to the wiper command decoder.
// Assumes an open-drain serial return line that has a pull-up.
module dpc_spi_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Idle levels
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // ==========================================================================
  // One whole frame, clock stands still outside it
  task automatic xfer(
    input  logic        mode3,
    input  logic [15:0] tx,
    output logic [15:0] rx
  );
    #7;
    cs_n = 1'b0;
    #15;
    for (int i = 15; i >= 0; i--) begin
      sclk  = 1'b0;
      sdi   = tx[i];
      #15;
      rx[i] = sdo_line;
      sclk  = 1'b1;
      #15;
    end
    if (!mode3) begin
      sclk = 1'b0;
    end
    #15;
    cs_n = 1'b1;
    // Released line shows no stale value
    sdi  = ~sdi;
  endtask : xfer

  // Mode 3 idle level, set between frames
  task automatic park_high;
    sclk = 1'b1;
  endtask : park_high
endmodule : dpc_spi_master

// *** sim/tb_dual_pot_spi_command_decoder.sv ***
// Self-checking bench for the dual wiper serial command decoder.
// Assumes the master model above and the default of two wipers.
module tb_dual_pot_spi_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  import dpc_pkg::*;

  logic        mclk;
  logic        nrst;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo_o;
  logic        sdo_oe;
  logic        sdo_line;
  logic [15:0] wiper_out;
  int          errors;
  int          num_checks;
  int          cyc;
  logic [7:0]  w [2];
  logic [7:0]  st [16];
  logic [15:0] prev_w;
  logic [7:0]  rb;
  logic        rb_v;
  logic        mode3;

  assign sdo_line = sdo_oe ? 1'b0 : 1'b1;

  dpc_decoder dut_u (
    .mclk      (mclk),
    .nrst      (nrst),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .sdo_o     (sdo_o),
    .sdo_oe    (sdo_oe),
    .wiper_out (wiper_out)
  );

  dpc_spi_master m_u (
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo_line (sdo_line)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // Checking helpers
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] step(input logic [3:0] c, input logic [7:0] v,
                                      input logic [7:0] d);
    case (c)
      4'h4, 4'h5: return v / 2;
      4'h6, 4'h7: return (v == 8'h00) ? v : v - 8'h01;
      4'hb:       return d;
      4'hc, 4'hd: return (v >= 8'h80) ? 8'hff : v * 2;
      4'he, 4'hf: return (v == 8'hff) ? v : v + 8'h01;
      default:    return v;
    endcase
  endfunction : step

  // Sends one word, updates the model and compares
  task automatic do_cmd(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
    logic [15:0] rx;
    logic [15:0] exp;
    m_u.xfer(mode3, {c, a, d}, rx);
    #1;
    chk("wiper before execute", {w[1], w[0]}, wiper_out);
    chk("sdo enable idle", 16'h0000, {15'h0, sdo_oe});
    chk("sdo value idle", {15'h0, c[3]}, {15'h0, sdo_o});
    exp = rb_v ? {prev_w[15:8], rb} : prev_w;
    chk("sdo frame", exp, rx);
    prev_w  = {c, a, d};
    rb_v    = (c == 4'h9) || (c == 4'ha && a < 4'h2);
    case (c)
      4'h1: if (a < 2) w[a[0]] = st[a];
      4'h2: if (a < 2) st[a] = w[a[0]];
      4'h3: st[a] = d;
      4'h4, 4'h6, 4'hb, 4'hc, 4'he: if (a < 2) w[a[0]] = step(c, w[a[0]], d);
      4'h5, 4'h7, 4'hd, 4'hf: for (int i = 0; i < 2; i++) w[i] = step(c, w[i], d);
      4'h8: if (a == 4'h0) for (int i = 0; i < 2; i++) w[i] = st[i];
      4'h9: rb = st[a];
      4'ha: rb = w[a[0]];
      default: ;
    endcase
    repeat (20) @(negedge mclk);
    chk("wiper after execute", {w[1], w[0]}, wiper_out);
  endtask : do_cmd

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk("wiper after power-up", {STORE_RESET_VAL, STORE_RESET_VAL}, wiper_out);
    chk("sdo enable in reset idle", 16'h0000, {15'h0, sdo_oe});
  endtask : t_reset

  task automatic t_direct;
    do_cmd(4'hb, 4'h0, 8'h5a);
    do_cmd(4'hb, 4'h1, 8'ha5);
    do_cmd(4'hb, 4'h2, 8'h33);
    do_cmd(4'h0, 4'h1, 8'hff);
    do_cmd(4'h4, 4'h0, 8'hff);
    do_cmd(4'hc, 4'h1, 8'h00);
    do_cmd(4'he, 4'h1, 8'h00);
    do_cmd(4'h6, 4'h0, 8'hff);
    do_cmd(4'hb, 4'h0, 8'h00);
    do_cmd(4'h6, 4'h0, 8'h00);
    do_cmd(4'h4, 4'h0, 8'h00);
    do_cmd(4'he, 4'h0, 8'hff);
    do_cmd(4'hc, 4'h0, 8'h00);
    do_cmd(4'he, 4'h3, 8'h00);
  endtask : t_direct

  task automatic t_store;
    do_cmd(4'h3, 4'h5, 8'h3c);
    do_cmd(4'h9, 4'h5, 8'h00);
    do_cmd(4'h2, 4'h0, 8'h00);
    do_cmd(4'hb, 4'h0, 8'h11);
    do_cmd(4'h1, 4'h0, 8'h00);
    do_cmd(4'h9, 4'h0, 8'h00);
    do_cmd(4'h3, 4'h1, 8'h77);
    do_cmd(4'h8, 4'h1, 8'h00);
    do_cmd(4'h8, 4'h0, 8'h00);
    do_cmd(4'ha, 4'h1, 8'h00);
    do_cmd(4'h1, 4'h2, 8'h00);
  endtask : t_store

  task automatic t_all;
    logic [3:0] seq [8];
    seq = '{4'h7, 4'hf, 4'hf, 4'h5, 4'hd, 4'hd, 4'hd, 4'h5};
    // Raising the idle level shifts one stray bit, the inverse of the last one
    m_u.park_high();
    prev_w = {prev_w[14:0], ~prev_w[0]};
    mode3  = 1'b1;
    do_cmd(4'hb, 4'h0, 8'h00);
    do_cmd(4'hb, 4'h1, 8'hfe);
    for (int i = 0; i < 8; i++) begin
      do_cmd(seq[i], 4'h9, 8'hc3);
    end
    do_cmd(4'h0, 4'h0, 8'h00);
  endtask : t_all

  // ==========================================================================
  // Main sequence
  initial begin
    nrst       = 1'b0;
    errors     = 0;
    num_checks = 0;
    cyc        = 0;
    prev_w     = 16'h0000;
    rb         = 8'h00;
    rb_v       = 1'b0;
    mode3      = 1'b0;
    for (int i = 0; i < 16; i++) st[i] = STORE_RESET_VAL;
    w[0] = STORE_RESET_VAL;
    w[1] = STORE_RESET_VAL;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    repeat (10) @(negedge mclk);
    t_reset();
    t_direct();
    t_store();
    t_all();
    close_out();
  end
endmodule : tb_dual_pot_spi_command_decoder

// *** src/dpc_decoder.sv ***
// Serial command decoder for a dual wiper setting block with nonvolatile store.
// Assumes an SPI master in mode 0 or mode 3; sclk only runs while cs_n is low.
module dpc_decoder #(
  parameter int NUM_WIPERS = dpc_pkg::NUM_WIPERS_DEF
) (
  input  wire logic                                  mclk,
  input  wire logic                                  nrst,
  input  wire logic                                  sclk,
  input  wire logic                                  cs_n,
  input  wire logic                                  sdi,
  output logic                                       sdo_o,
  output logic                                       sdo_oe,
  output logic [NUM_WIPERS*dpc_pkg::DATA_W-1:0]      wiper_out
);
  import dpc_pkg::*;

  localparam logic [ADDR_W-1:0] LAST_IDX = ADDR_W'(NUM_WIPERS - 1);
  localparam logic [ADDR_W:0]   NW_LIM   = (ADDR_W + 1)'(NUM_WIPERS);
  localparam logic [ADDR_W:0]   SD_LIM   = (ADDR_W + 1)'(STORE_DEPTH);

  // Link domain
  logic [WORD_W-1:0] shreg_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              use_rb_reg;
  logic              rb_meta_reg;
  logic              rb_sync_reg;
  logic              rb_ack_reg;
  logic              rb_pend;
  logic              tx_bit;
  logic              link_rst_n;

  // Core domain
  logic              cs_meta_reg;
  logic              cs_sync_reg;
  logic              cs_prev_reg;
  logic              exec_pulse;
  dpc_word_t         word_reg;
  dpc_state_t        state_reg;
  logic [ADDR_W-1:0] idx_reg;
  logic              all_reg;
  logic [DATA_W-1:0] rb_byte_reg;
  logic              rb_tgl_reg;
  logic [DATA_W-1:0] wiper_reg [NUM_WIPERS];
  logic [DATA_W-1:0] wiper_at;
  logic              wiper_ok;
  logic              store_ok;
  logic              need_fetch;
  logic              is_group;
  logic              is_addr_adj;
  logic [ADDR_W-1:0] st_rd_addr;
  logic [DATA_W-1:0] st_rd_data;
  logic              st_wr_en;
  logic [DATA_W-1:0] st_wr_data;

  // ==========================================================================
  // Link side: shift register and serial output
  assign link_rst_n = nrst & ~cs_n;

  // Both supported modes sample on the rising edge
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      shreg_reg <= '0;
    end else begin
      shreg_reg <= {shreg_reg[WORD_W-2:0], sdi};
    end
  end

  // Bit position within the word, cleared by the frame's own chip select
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // Readback flag from the core side, by toggle
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      rb_meta_reg <= 1'b0;
      rb_sync_reg <= 1'b0;
    end else begin
      rb_meta_reg <= rb_tgl_reg;
      rb_sync_reg <= rb_meta_reg;
    end
  end

  assign rb_pend = rb_sync_reg ^ rb_ack_reg;

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      rb_ack_reg <= 1'b0;
    end else if (cnt_reg == RB_SWITCH_CNT && rb_pend) begin
      rb_ack_reg <= rb_sync_reg;
    end
  end

  // Readback byte replaces the low byte for the second half of the word
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      use_rb_reg <= 1'b0;
    end else if (cnt_reg == RB_SWITCH_CNT) begin
      use_rb_reg <= rb_pend;
    end else if (cnt_reg == LAST_BIT_CNT) begin
      use_rb_reg <= 1'b0;
    end
  end

  assign tx_bit = use_rb_reg ? rb_byte_reg[~cnt_reg[2:0]] : shreg_reg[WORD_W-1];
  assign sdo_o  = tx_bit;
  assign sdo_oe = ~cs_n & ~tx_bit;

  // ==========================================================================
  // Core side: chip select release and word capture
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  assign exec_pulse = cs_sync_reg & ~cs_prev_reg;

  // Shift register only shifts on rising sclk, so it is still while chip select is high and sclk is idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      word_reg <= '0;
    end else if (exec_pulse) begin
      word_reg <= dpc_word_t'(shreg_reg);
    end
  end

  // ==========================================================================
  // Decode
  assign wiper_ok    = {1'b0, word_reg.addr} < NW_LIM;
  assign store_ok    = {1'b0, word_reg.addr} < SD_LIM;
  assign is_group    = word_reg.cmd inside {CMD_SHR_ALL, CMD_DEC_ALL, CMD_SHL_ALL, CMD_INC_ALL};
  assign is_addr_adj = word_reg.cmd inside {CMD_SHR_ONE, CMD_DEC_ONE, CMD_WR_WIPER,
                                            CMD_SHL_ONE, CMD_INC_ONE};
  assign need_fetch  = (word_reg.cmd == CMD_LD_WIPER && wiper_ok)
                     || (word_reg.cmd == CMD_RELOAD_ALL && word_reg.addr == RELOAD_ADDR)
                     || (word_reg.cmd == CMD_RD_STORE && store_ok);

  always_comb begin
    wiper_at = '0;
    for (int i = 0; i < NUM_WIPERS; i++) begin
      if (word_reg.addr == ADDR_W'(i)) begin
        wiper_at = wiper_reg[i];
      end
    end
  end

  // ==========================================================================
  // Sequencer; reset starts a full reload
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_FETCH;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (exec_pulse) begin
            state_reg <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          state_reg <= need_fetch ? ST_FETCH : ST_IDLE;
        end
        ST_FETCH: begin
          state_reg <= ST_LOAD;
        end
        ST_LOAD: begin
          state_reg <= (all_reg && idx_reg != LAST_IDX) ? ST_FETCH : ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idx_reg <= '0;
      all_reg <= 1'b1;
    end else if (state_reg == ST_DECODE) begin
      idx_reg <= '0;
      all_reg <= (word_reg.cmd == CMD_RELOAD_ALL);
    end else if (state_reg == ST_LOAD && all_reg) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  // ==========================================================================
  // Store access
  assign st_rd_addr = all_reg ? idx_reg : word_reg.addr;
  assign st_wr_en   = (state_reg == ST_DECODE)
                    && ((word_reg.cmd == CMD_SAVE && wiper_ok)
                     || (word_reg.cmd == CMD_WR_STORE && store_ok));
  assign st_wr_data = (word_reg.cmd == CMD_SAVE) ? wiper_at : word_reg.data;

  dpc_store #(
    .DEPTH     (STORE_DEPTH),
    .AW        (ADDR_W),
    .WIDTH     (DATA_W),
    .RESET_VAL (STORE_RESET_VAL)
  ) u_store (
    .mclk    (mclk),
    .nrst    (nrst),
    .rd_addr (st_rd_addr),
    .rd_data (st_rd_data),
    .wr_en   (st_wr_en),
    .wr_addr (word_reg.addr),
    .wr_data (st_wr_data)
  );

  // ==========================================================================
  // Readback byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rb_byte_reg <= '0;
      rb_tgl_reg  <= 1'b0;
    end else if (state_reg == ST_DECODE && word_reg.cmd == CMD_RD_WIPER && wiper_ok) begin
      rb_byte_reg <= wiper_at;
      rb_tgl_reg  <= ~rb_tgl_reg;
    end else if (state_reg == ST_LOAD && !all_reg && word_reg.cmd == CMD_RD_STORE) begin
      rb_byte_reg <= st_rd_data;
      rb_tgl_reg  <= ~rb_tgl_reg;
    end
  end

  // ==========================================================================
  // Wipers
  for (genvar gi = 0; gi < NUM_WIPERS; gi++) begin : g_wiper
    logic ld_hit;
    logic adj_hit;

    assign ld_hit  = (state_reg == ST_LOAD)
                   && ((all_reg && idx_reg == ADDR_W'(gi))
                    || (!all_reg && word_reg.cmd == CMD_LD_WIPER && word_reg.addr == ADDR_W'(gi)));
    assign adj_hit = (state_reg == ST_DECODE)
                   && (is_group || (is_addr_adj && word_reg.addr == ADDR_W'(gi)));

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        wiper_reg[gi] <= WIPER_RESET_VAL;
      end else if (ld_hit) begin
        wiper_reg[gi] <= st_rd_data;
      end else if (adj_hit) begin
        wiper_reg[gi] <= dpc_adjust(word_reg.cmd, wiper_reg[gi], word_reg.data);
      end
    end

    assign wiper_out[gi*DATA_W +: DATA_W] = wiper_reg[gi];
  end

  // ==========================================================================
  // Checks
  nop_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_NOP)
      |=> $stable(wiper_out) && $stable(rb_tgl_reg) && !$past(st_wr_en))
    else $error("nop changed state");

  wr_wiper_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_WR_WIPER && word_reg.addr == 4'h0)
      |=> wiper_out[7:0] == $past(word_reg.data))
    else $error("direct wiper write lost");

  dec_sat_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_DEC_ONE && word_reg.addr == 4'h0)
      |=> wiper_out[7:0] == (($past(wiper_out[7:0]) == 8'h00) ? 8'h00
                             : $past(wiper_out[7:0]) - 8'h01))
    else $error("decrement wrong");

  inc_all_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_INC_ALL && wiper_out[7:0] != 8'hff)
      |=> wiper_out[7:0] == $past(wiper_out[7:0]) + 8'h01)
    else $error("increment all wrong");

  shr_one_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_SHR_ONE && word_reg.addr == 4'h0)
      |=> wiper_out[7:0] == {1'b0, $past(wiper_out[7:1])} && $stable(wiper_out[15:8]))
    else $error("right shift wrong");

  shl_all_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_SHL_ALL && wiper_out[15])
      |=> wiper_out[15:8] == 8'hff)
    else $error("left shift not saturating");

  exec_wait_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_IDLE && !exec_pulse) |=> state_reg == ST_IDLE)
    else $error("command ran without chip select release");

  save_data_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_SAVE && word_reg.addr == 4'h0)
      |-> st_wr_en && st_wr_data == wiper_out[7:0])
    else $error("save wrote wrong value");

  rd_wiper_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_RD_WIPER && word_reg.addr == 4'h1)
      |=> rb_byte_reg == $past(wiper_out[15:8]) && rb_tgl_reg != $past(rb_tgl_reg))
    else $error("wiper readback wrong");

  bad_addr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && is_addr_adj && !wiper_ok) |=> $stable(wiper_out))
    else $error("absent wiper was changed");

  reload_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == ST_DECODE && word_reg.cmd == CMD_RELOAD_ALL && word_reg.addr == 4'h0)
      |=> state_reg == ST_FETCH ##1 state_reg == ST_LOAD ##1 state_reg == ST_FETCH
          ##1 state_reg == ST_LOAD ##1 state_reg == ST_IDLE)
    else $error("reload sequence wrong");

  sdo_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    cs_n |-> !sdo_oe)
    else $error("serial output driven while deselected");

endmodule : dpc_decoder

// *** src/dpc_pkg.sv ***
// Shared constants, types and helpers for the dual wiper serial command decoder.
// Assumes a 16-bit serial word, eight-bit wipers and a sixteen-entry store.
package dpc_pkg;

  // ==========================================================================
  // Word layout and sizes
  localparam int WORD_W         = 16;
  localparam int CMD_W          = 4;
  localparam int ADDR_W         = 4;
  localparam int DATA_W         = 8;
  localparam int CNT_W          = 4;
  localparam int NUM_WIPERS_DEF = 2;
  localparam int STORE_DEPTH    = 16;

  // ==========================================================================
  // Values
  localparam logic [DATA_W-1:0] WIPER_ONES      = 8'hff;
  localparam logic [DATA_W-1:0] WIPER_ZERO      = 8'h00;
  localparam logic [DATA_W-1:0] WIPER_RESET_VAL = 8'h00;
  localparam logic [DATA_W-1:0] STORE_RESET_VAL = 8'h80;
  localparam logic [ADDR_W-1:0] RELOAD_ADDR     = 4'h0;
  localparam logic [CNT_W-1:0]  RB_SWITCH_CNT   = 4'h7;
  localparam logic [CNT_W-1:0]  LAST_BIT_CNT    = 4'hf;

  // ==========================================================================
  // Commands
  typedef enum logic [CMD_W-1:0] {
    CMD_NOP        = 4'h0,
    CMD_LD_WIPER   = 4'h1,
    CMD_SAVE       = 4'h2,
    CMD_WR_STORE   = 4'h3,
    CMD_SHR_ONE    = 4'h4,
    CMD_SHR_ALL    = 4'h5,
    CMD_DEC_ONE    = 4'h6,
    CMD_DEC_ALL    = 4'h7,
    CMD_RELOAD_ALL = 4'h8,
    CMD_RD_STORE   = 4'h9,
    CMD_RD_WIPER   = 4'ha,
    CMD_WR_WIPER   = 4'hb,
    CMD_SHL_ONE    = 4'hc,
    CMD_SHL_ALL    = 4'hd,
    CMD_INC_ONE    = 4'he,
    CMD_INC_ALL    = 4'hf
  } dpc_cmd_t;

  typedef struct packed {
    dpc_cmd_t            cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } dpc_word_t;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_LOAD,
    ST_IDLE,
    ST_DECODE
  } dpc_state_t;

  // ==========================================================================
  // Saturating wiper adjustment
  function automatic logic [DATA_W-1:0] dpc_adjust(
    input dpc_cmd_t          cmd,
    input logic [DATA_W-1:0] val,
    input logic [DATA_W-1:0] data
  );
    logic [DATA_W-1:0] res;
    res = val;
    case (cmd)
      CMD_SHR_ONE, CMD_SHR_ALL: res = {1'b0, val[DATA_W-1:1]};
      CMD_DEC_ONE, CMD_DEC_ALL: res = (val == WIPER_ZERO) ? val : val - 8'h01;
      CMD_WR_WIPER:             res = data;
      CMD_SHL_ONE, CMD_SHL_ALL: res = val[DATA_W-1] ? WIPER_ONES : {val[DATA_W-2:0], 1'b0};
      CMD_INC_ONE, CMD_INC_ALL: res = (val == WIPER_ONES) ? val : val + 8'h01;
      default:                  res = val;
    endcase
    return res;
  endfunction : dpc_adjust

endpackage : dpc_pkg

// *** src/dpc_store.sv ***
// Nonvolatile setting store: one write port, registered read data.
// Assumes the caller keeps the read address steady for one cycle before use.
module dpc_store #(
  parameter int                DEPTH     = 16,
  parameter int                AW        = 4,
  parameter int                WIDTH     = 8,
  parameter logic [WIDTH-1:0]  RESET_VAL = 8'h80
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // ==========================================================================
  // Storage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= RESET_VAL;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule : dpc_store
